// ---- adc_result_serial_port_test.sv ----
`timescale 1ns/10ps
module adc_result_serial_port_test;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cs_n_in, sck_pin, host_sck, sck_internal, tb_sck = 1'b0;
  logic sck_out, sck_oe_n_out, serial_data_out, serial_data_oe_n_out;
  logic conv_done, conv_start_out, conv_busy_out, conv_speed_2x_out, conv_temp_out;
  logic signed [19:0] conv_value;
  logic [2:0] conv_gain_out;
  logic [4:0] cfg;
  logic rej_wr, rej_pin;
  logic [1:0] rej_mode, rejection_mode_out;
  logic conv_clk_tick_out, filter_frame_tick_out, int_osc_en_out, ext_clk_present_out;
  logic [4:0] cfg_q[$];
  int num_errors = 0, compares = 0, cycles = 0, ticks = 0, frames = 0, starts = 0;
  int vals[8] = '{0, -1, -65536, -65537, 65535, 65536, 200000, -300000};

  always #25 ref_clk_in = ~ref_clk_in;
  assign sck_pin = (sck_oe_n_out === 1'b0) ? sck_out : (host_sck ^ tb_sck);

  arsp_result_port #(.OUT_MAX_CYC(480), .INT_OSC_DIV(4), .DET_CYC(50), .NOTCH_DIV(8)) u_dut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in), .sck_in(sck_pin),
    .sck_internal_in(sck_internal), .sck_out(sck_out), .sck_oe_n_out(sck_oe_n_out),
    .serial_data_out(serial_data_out), .serial_data_oe_n_out(serial_data_oe_n_out),
    .conv_done_in(conv_done), .conv_value_in(conv_value), .conv_start_out(conv_start_out),
    .conv_busy_out(conv_busy_out), .conv_gain_out(conv_gain_out), .conv_speed_2x_out(conv_speed_2x_out),
    .conv_temp_out(conv_temp_out), .gain_select_hi_in(cfg[4]), .gain_select_mid_in(cfg[3]),
    .gain_select_lo_in(cfg[2]), .temp_input_select_in(cfg[1]), .speed_2x_in(cfg[0]),
    .rejection_wr_in(rej_wr), .rejection_mode_in(rej_mode), .rejection_mode_out(rejection_mode_out),
    .rejection_clock_pin_in(rej_pin), .conv_clk_tick_out(conv_clk_tick_out),
    .filter_frame_tick_out(filter_frame_tick_out), .int_osc_en_out(int_osc_en_out),
    .ext_clk_present_out(ext_clk_present_out));

  arsp_host_model #(.HALF(4)) u_host (.clk_in(ref_clk_in), .sck_pin_in(sck_pin),
    .sdo_in(serial_data_out), .cs_n_out(cs_n_in), .sck_out(host_sck));

  task automatic final_report;
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  always @(posedge ref_clk_in) begin
    cycles++;
    if (conv_clk_tick_out === 1'b1) ticks++;
    if (filter_frame_tick_out === 1'b1) frames++;
    if (conv_start_out === 1'b1) starts++;
    if (cycles == 60000) begin
      num_errors++;
      final_report();
    end
  end

  // Expected word from a raw code and the settings latched at its start
  function automatic logic [23:0] exp_word(input int v, input logic [4:0] c);
    int cv;
    logic [16:0] r;
    cv = (v > 65536) ? 65536 : ((v < -65537) ? -65537 : v);
    r = cv[16:0];
    return {2'b00, cv >= 0, r, c[1] ? 3'h0 : c[4:2], c[1]};
  endfunction : exp_word

  // Play the converter: wait for busy, then hand over one result
  task automatic convert(input int v, input bit cs_early);
    logic [4:0] c;
    int i;
    c = cfg_q[0];
    i = 0;
    while (conv_busy_out !== 1'b1 && i < 50) begin
      @(negedge ref_clk_in);
      i++;
    end
    check(conv_busy_out, 1);
    check(conv_gain_out, c[1] ? 3'h0 : c[4:2]);
    check({conv_temp_out, conv_speed_2x_out}, {c[1], c[0] & ~c[1]});
    if (cs_early) begin
      u_host.select(1'b0);
      repeat (3) @(negedge ref_clk_in);
      check(serial_data_out, 1);
    end
    conv_value = v[19:0];
    conv_done = 1'b1;
    @(negedge ref_clk_in);
    conv_done = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    if (cs_early) check(serial_data_out, 0);
    check(conv_busy_out, 0);
  endtask : convert

  // Read n bits and compare; a fresh setting is latched at the next start
  task automatic read_check(input int v, input int n, input bit internal);
    logic [31:0] w, e;
    logic [4:0] c;
    c = cfg_q.pop_front();
    cfg = 5'($urandom());
    cfg_q.push_back(cfg);
    u_host.xfer(n, internal, w);
    if (n >= 24) e = ({8'h00, exp_word(v, c)} << (n - 24)) | ((32'h1 << (n - 24)) - 1);
    else e = {8'h00, exp_word(v, c)} >> (24 - n);
    check(w, e);
    repeat (2) @(negedge ref_clk_in);
    check(serial_data_oe_n_out, 1);
  endtask : read_check

  initial begin
    int t0, f0, v;
    void'($urandom(59938));
    sck_internal = 1'b0;
    conv_done = 1'b0;
    conv_value = '0;
    rej_wr = 1'b0;
    rej_pin = 1'b0;
    rej_mode = 2'h0;
    cfg = 5'($urandom());
    cfg_q.push_back(cfg);
    repeat (4) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    check({rejection_mode_out, int_osc_en_out, ext_clk_present_out}, 4'h2);
    for (int i = 0; i < 8; i++) begin
      convert(vals[i], i == 1);
      read_check(vals[i], (i % 3 == 2) ? 32 : 24, 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      v = int'($urandom_range(140000)) - 70000;
      convert(v, 1'b0);
      read_check(v, 24, 1'b0);
    end
    convert(1234, 1'b0);
    read_check(1234, 10, 1'b0);
    convert(-4321, 1'b0);
    repeat (6) begin
      @(negedge ref_clk_in);
      tb_sck = ~tb_sck;
    end
    read_check(-4321, 24, 1'b0);
    convert(777, 1'b0);
    sck_internal = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    check(sck_oe_n_out, 0);
    read_check(777, 24, 1'b1);
    sck_internal = 1'b0;
    foreach (vals[i]) if (i < 3) begin
      rej_mode = 2'(3 - i) & 2'h2 | 2'(i == 0);
      rej_wr = 1'b1;
      @(negedge ref_clk_in);
      rej_wr = 1'b0;
      @(negedge ref_clk_in);
      check(rejection_mode_out, rej_mode);
    end
    t0 = ticks;
    f0 = frames;
    repeat (160) begin
      rej_pin = 1'b1;
      repeat (3) @(negedge ref_clk_in);
      rej_pin = 1'b0;
      repeat (3) @(negedge ref_clk_in);
    end
    check({ext_clk_present_out, int_osc_en_out}, 2'b10);
    check(ticks - t0 >= 158 && ticks - t0 <= 160, 1);
    check(frames - f0 >= 19 && frames - f0 <= 21, 1);
    repeat (60) @(negedge ref_clk_in);
    check({ext_clk_present_out, int_osc_en_out}, 2'b01);
    t0 = ticks;
    repeat (400) @(negedge ref_clk_in);
    check(ticks - t0 >= 99 && ticks - t0 <= 101, 1);
    check(starts, 16);
    final_report();
  end
endmodule : adc_result_serial_port_test

// ---- arsp_cclk_gen.sv ----
`timescale 1ns/10ps
`include "arsp_consts.svh"
module arsp_cclk_gen #(
  parameter int unsigned INT_OSC_DIV = `ARSP_INT_OSC_DIV,
  parameter int unsigned DET_CYC = `ARSP_EXT_DET_CYC,
  parameter int unsigned NOTCH_DIV = `ARSP_NOTCH_DIV
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Rejection clock pin
  input wire logic rejection_clock_pin_in,
  // Conversion clock status and ticks
  arsp_cclk_if.src cif
);

  localparam logic [11:0] DET_L = 12'(DET_CYC);
  localparam logic [7:0] OSC_L = 8'(INT_OSC_DIV - 1);
  localparam logic [12:0] NOTCH_L = 13'(NOTCH_DIV - 1);

  logic pin_q_r;
  logic [11:0] idle_cnt_r;
  logic [7:0] osc_cnt_r;
  logic [12:0] frame_cnt_r;
  logic pin_rise;
  logic osc_wrap;
  logic tick_nxt;

  assign pin_rise = rejection_clock_pin_in & ~pin_q_r;
  assign osc_wrap = cif.osc_en & (osc_cnt_r == OSC_L);
  assign tick_nxt = cif.ext_present ? pin_rise : osc_wrap;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pin_q_r <= 1'b0;
    end else begin
      pin_q_r <= rejection_clock_pin_in;
    end
  end

  // External clock detection and oscillator shutdown
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      idle_cnt_r <= 12'h000;
      cif.ext_present <= 1'b0;
      cif.osc_en <= 1'b1;
    end else if (pin_rise) begin
      idle_cnt_r <= 12'h000;
      cif.ext_present <= 1'b1; // RULE16
      cif.osc_en <= 1'b0; // RULE16
    end else if (idle_cnt_r == DET_L) begin
      cif.ext_present <= 1'b0; // RULE18
      cif.osc_en <= 1'b1; // RULE18
    end else begin
      idle_cnt_r <= idle_cnt_r + 12'h001;
    end
  end

  // Internal oscillator divider, stopped while an external clock runs
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || !cif.osc_en || osc_wrap) begin
      osc_cnt_r <= 8'h00;
    end else begin
      osc_cnt_r <= osc_cnt_r + 8'h01;
    end
  end

  // Conversion clock tick and filter frame; a source change only shifts tick timing
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      cif.conv_tick <= 1'b0;
      cif.frame_tick <= 1'b0;
      frame_cnt_r <= 13'h0000;
    end else begin
      cif.conv_tick <= tick_nxt; // RULE19
      cif.frame_tick <= tick_nxt & (frame_cnt_r == NOTCH_L); // RULE17
      if (tick_nxt) begin
        frame_cnt_r <= (frame_cnt_r == NOTCH_L) ? 13'h0000 : frame_cnt_r + 13'h0001;
      end
    end
  end

  AST_EXT_LOSS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE18
    (idle_cnt_r == DET_L && !pin_rise) |=> (!cif.ext_present && cif.osc_en))
    else $error("external clock loss did not re-enable the oscillator");

  AST_EXT_FOUND: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE16
    pin_rise |=> (cif.ext_present && !cif.osc_en && idle_cnt_r == 12'h000))
    else $error("external clock edge did not stop the oscillator");

  AST_FRAME_DIV: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE17
    cif.frame_tick |-> ($past(frame_cnt_r) == NOTCH_L && cif.conv_tick))
    else $error("filter frame tick not on the last conversion tick");

endmodule : arsp_cclk_gen

// ---- arsp_cclk_if.sv ----
`timescale 1ns/10ps
interface arsp_cclk_if;
  logic conv_tick;
  logic frame_tick;
  logic ext_present;
  logic osc_en;
  modport src (output conv_tick, output frame_tick, output ext_present, output osc_en);
  modport sink (input conv_tick, input frame_tick, input ext_present, input osc_en);
endinterface : arsp_cclk_if

// ---- arsp_consts.svh ----
`ifndef ARSP_CONSTS_SVH
`define ARSP_CONSTS_SVH

// Clock
`define ARSP_CLK_PERIOD_NS 50

// Output word layout
`define ARSP_BIT_EOC 23
`define ARSP_BIT_FILL 22
`define ARSP_BIT_SIGN 21
`define ARSP_BIT_MSB 20
`define ARSP_LAST_FALL 5'h17
`define ARSP_SCK_CYCLES 24

// Result clamp limits, full scale plus and minus one step
`define ARSP_POS_CLAMP 20'sh1_0000
`define ARSP_NEG_CLAMP 20'shE_FFFF

// Configuration reset values
`define ARSP_REJ_DEFAULT 2'h0

// Conversion clock
`define ARSP_EXT_MIN_KHZ 10
`define ARSP_EXT_DET_CYC ((1000000 / `ARSP_EXT_MIN_KHZ + `ARSP_CLK_PERIOD_NS - 1) / `ARSP_CLK_PERIOD_NS)
`define ARSP_NOTCH_DIV 5120
`define ARSP_INT_OSC_DIV 64

// Internal serial clock output phase limit
`define ARSP_OUT_MAX_US 620
`define ARSP_OUT_MAX_CYC ((`ARSP_OUT_MAX_US * 1000) / `ARSP_CLK_PERIOD_NS)

`endif

// ---- arsp_host_model.sv ----
`timescale 1ns/10ps
module arsp_host_model #(
  parameter int HALF = 4
) (
  // Clock and pins
  input wire logic clk_in,
  input wire logic sck_pin_in,
  input wire logic sdo_in,
  output logic cs_n_out,
  output logic sck_out
);
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
  end

  // Drive chip select alone
  task automatic select(input logic lvl);
    @(negedge clk_in);
    cs_n_out <= lvl;
  endtask : select

  // Shift n bits, bit 23 first; internal uses the device-made clock
  task automatic xfer(input int n, input bit internal, output logic [31:0] w);
    w = '0;
    @(negedge clk_in);
    cs_n_out <= 1'b0;
    repeat (HALF) @(negedge clk_in);
    for (int k = 0; k < n; k++) begin
      if (internal) begin
        @(negedge sck_pin_in);
        w = {w[30:0], sdo_in};
      end else begin
        sck_out <= 1'b1;
        repeat (HALF) @(negedge clk_in);
        w = {w[30:0], sdo_in};
        sck_out <= 1'b0;
        repeat (HALF) @(negedge clk_in);
      end
    end
    @(negedge clk_in);
    cs_n_out <= 1'b1;
  endtask : xfer
endmodule : arsp_host_model

// ---- arsp_pkg.sv ----
package arsp_pkg;

  typedef enum logic [1:0] {
    ARSP_ST_CONV = 2'b00,
    ARSP_ST_SLEEP = 2'b01,
    ARSP_ST_SHIFT = 2'b10
  } arsp_state_t;

  typedef logic [3:0] arsp_echo_t;

endpackage : arsp_pkg

// ---- arsp_result_port.sv ----
`timescale 1ns/10ps
`include "arsp_consts.svh"
// Functional notes
// RULE1 - 24-bit word: status, 17-bit result, echo
// RULE2 - Extra clocks after 24th ignored, output one
// RULE3 - Early chip select rise aborts, restarts conversion
// RULE4 - Bit 23 high converting, low when done
// RULE5 - Bit 22 filler always low
// RULE6 - Bit 21 high for positive or zero
// RULE7 - Bits 21,20 both high over, low under
// RULE8 - Last four bits echo gain and temp
// RULE9 - Zero, minus one, minus full scale codes
// RULE10 - Out of range clamps one step beyond
// RULE11 - Chip select high: output off, clocks ignored
// RULE12 - Done flag on output changes in real time
// RULE13 - Each later bit presented on falling edge
// RULE14 - After 24th fall, next done flag shown
// RULE15 - Rejection mode written, defaults simultaneous 50/60
// RULE16 - Detect external clock, stop internal oscillator
// RULE17 - External clock notch at frequency over 5120
// RULE18 - No external clock: internal oscillator mode
// RULE19 - Clock source change does not disturb output
// RULE20 - Internal clock output: 24 cycles, 0.62ms
// RULE21 - Temperature select forces gain one, normal speed
// RULE22 - Result captured at completion, held through sleep
module arsp_result_port #(
  parameter int unsigned OUT_MAX_CYC = `ARSP_OUT_MAX_CYC,
  parameter int unsigned INT_OSC_DIV = `ARSP_INT_OSC_DIV,
  parameter int unsigned DET_CYC = `ARSP_EXT_DET_CYC,
  parameter int unsigned NOTCH_DIV = `ARSP_NOTCH_DIV
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Serial port pins
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic sck_internal_in,
  output logic sck_out,
  output logic sck_oe_n_out,
  output logic serial_data_out,
  output logic serial_data_oe_n_out,
  // Conversion engine
  input wire logic conv_done_in,
  input wire logic signed [19:0] conv_value_in,
  output logic conv_start_out,
  output logic conv_busy_out,
  output logic [2:0] conv_gain_out,
  output logic conv_speed_2x_out,
  output logic conv_temp_out,
  // Configuration
  input wire logic gain_select_hi_in,
  input wire logic gain_select_mid_in,
  input wire logic gain_select_lo_in,
  input wire logic temp_input_select_in,
  input wire logic speed_2x_in,
  input wire logic rejection_wr_in,
  input wire logic [1:0] rejection_mode_in,
  output logic [1:0] rejection_mode_out,
  // Conversion clock
  input wire logic rejection_clock_pin_in,
  output logic conv_clk_tick_out,
  output logic filter_frame_tick_out,
  output logic int_osc_en_out,
  output logic ext_clk_present_out
);

  localparam logic [13:0] OUT_MAX_L = 14'(OUT_MAX_CYC);
  localparam logic [8:0] HALF_L = 9'(OUT_MAX_CYC / (2 * `ARSP_SCK_CYCLES) - 1);

  arsp_pkg::arsp_state_t state_r;
  arsp_pkg::arsp_state_t state_nxt;
  logic [4:0] bit_cnt_r;
  logic [23:0] word_r;
  logic sck_q_r;
  logic sck_gen_r;
  logic [8:0] half_cnt_r;
  logic [13:0] out_tmr_r;
  logic boot_r;
  logic conv_start_r;
  logic conv_busy_r;
  logic [2:0] conv_gain_r;
  logic conv_speed_r;
  logic conv_temp_r;
  logic [1:0] rej_r;
  logic sdo_r;
  logic sdo_nxt;
  logic sdo_oe_n_r;
  logic sck_oe_n_r;
  logic tick_r;
  logic frame_r;
  logic osc_en_r;
  logic ext_r;
  logic sck_eff;
  logic sck_fall;
  logic end_out;
  logic start_nxt;
  logic gen_run;

  arsp_cclk_if cif ();

  arsp_cclk_gen #(
    .INT_OSC_DIV(INT_OSC_DIV),
    .DET_CYC(DET_CYC),
    .NOTCH_DIV(NOTCH_DIV)
  ) u_cclk (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .rejection_clock_pin_in(rejection_clock_pin_in),
    .cif(cif)
  );

  // Result coding with clamping one step beyond full scale
  function automatic logic [17:0] arsp_encode(input logic signed [19:0] v);
    logic signed [19:0] c;
    c = v;
    if (v > `ARSP_POS_CLAMP) begin
      c = `ARSP_POS_CLAMP; // RULE10
    end else if (v < `ARSP_NEG_CLAMP) begin
      c = `ARSP_NEG_CLAMP; // RULE10
    end
    arsp_encode = {~c[19], c[16:0]}; // RULE6 RULE7 RULE9
  endfunction : arsp_encode

  // Serial clock source and falling edge, ignored while deselected
  assign sck_eff = sck_internal_in ? sck_gen_r : sck_in;
  assign sck_fall = sck_q_r & ~sck_eff & ~cs_n_in; // RULE11

  assign end_out = (state_r == arsp_pkg::ARSP_ST_SHIFT) &&
                   (cs_n_in || // RULE3
                    (sck_fall && bit_cnt_r == `ARSP_LAST_FALL) || // RULE14
                    (sck_internal_in && out_tmr_r == OUT_MAX_L)); // RULE20
  assign start_nxt = boot_r | end_out;
  assign gen_run = sck_internal_in && !cs_n_in && !end_out &&
                   (state_r == arsp_pkg::ARSP_ST_SLEEP || state_r == arsp_pkg::ARSP_ST_SHIFT);

  // Port state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      arsp_pkg::ARSP_ST_CONV: begin
        if (conv_done_in) begin
          state_nxt = arsp_pkg::ARSP_ST_SLEEP;
        end
      end
      arsp_pkg::ARSP_ST_SLEEP: begin
        if (sck_fall) begin
          state_nxt = arsp_pkg::ARSP_ST_SHIFT; // RULE13
        end
      end
      arsp_pkg::ARSP_ST_SHIFT: begin
        if (end_out) begin
          state_nxt = arsp_pkg::ARSP_ST_CONV; // RULE3 RULE14
        end
      end
      default: begin
        state_nxt = arsp_pkg::ARSP_ST_CONV;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_r <= arsp_pkg::ARSP_ST_CONV;
      boot_r <= 1'b1;
      conv_start_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      boot_r <= 1'b0;
      conv_start_r <= start_nxt;
    end
  end

  // Bit counter advanced on falling serial clock edges
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || end_out || state_r == arsp_pkg::ARSP_ST_CONV) begin
      bit_cnt_r <= 5'h00; // RULE2
    end else if (sck_fall) begin
      bit_cnt_r <= bit_cnt_r + 5'h01; // RULE13
    end
  end

  // Result word capture at completion, held until the next completion
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      word_r <= 24'h00_0000;
    end else if (state_r == arsp_pkg::ARSP_ST_CONV && conv_done_in) begin
      word_r <= {1'b0, 1'b0, arsp_encode(conv_value_in), conv_gain_r, conv_temp_r}; // RULE1 RULE5 RULE8 RULE22
    end
  end

  // Conversion settings latched at start; temperature input overrides
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      conv_gain_r <= 3'h0;
      conv_speed_r <= 1'b0;
      conv_temp_r <= 1'b0;
    end else if (start_nxt) begin
      conv_gain_r <= temp_input_select_in ? 3'h0 :
                     {gain_select_hi_in, gain_select_mid_in, gain_select_lo_in}; // RULE21
      conv_speed_r <= temp_input_select_in ? 1'b0 : speed_2x_in; // RULE21
      conv_temp_r <= temp_input_select_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      conv_busy_r <= 1'b0;
    end else if (start_nxt) begin
      conv_busy_r <= 1'b1;
    end else if (conv_done_in) begin
      conv_busy_r <= 1'b0;
    end
  end

  // Line rejection mode
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rej_r <= `ARSP_REJ_DEFAULT; // RULE15
    end else if (rejection_wr_in) begin
      rej_r <= rejection_mode_in; // RULE15
    end
  end

  // Internal serial clock generator and output phase timer
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || !gen_run) begin
      sck_gen_r <= 1'b1;
      half_cnt_r <= 9'h000;
    end else if (half_cnt_r == HALF_L) begin
      sck_gen_r <= ~sck_gen_r; // RULE20
      half_cnt_r <= 9'h000;
    end else begin
      half_cnt_r <= half_cnt_r + 9'h001;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || !gen_run) begin
      out_tmr_r <= 14'h0000;
    end else if (out_tmr_r != OUT_MAX_L) begin
      out_tmr_r <= out_tmr_r + 14'h0001; // RULE20
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sck_q_r <= 1'b1;
    end else begin
      sck_q_r <= sck_eff;
    end
  end

  // Serial data output selection
  always_comb begin
    sdo_nxt = 1'b1;
    case (state_r)
      arsp_pkg::ARSP_ST_CONV: begin
        sdo_nxt = 1'b1; // RULE2 RULE4 RULE12
      end
      arsp_pkg::ARSP_ST_SLEEP: begin
        sdo_nxt = 1'b0; // RULE4 RULE12
      end
      arsp_pkg::ARSP_ST_SHIFT: begin
        sdo_nxt = word_r[5'd23 - bit_cnt_r]; // RULE1 RULE13
      end
      default: begin
        sdo_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sdo_r <= 1'b1;
      sdo_oe_n_r <= 1'b1;
      sck_oe_n_r <= 1'b1;
    end else begin
      sdo_r <= sdo_nxt;
      sdo_oe_n_r <= cs_n_in; // RULE11
      sck_oe_n_r <= ~sck_internal_in;
    end
  end

  // Conversion clock status registered to the pins
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      tick_r <= 1'b0;
      frame_r <= 1'b0;
      osc_en_r <= 1'b1;
      ext_r <= 1'b0;
    end else begin
      tick_r <= cif.conv_tick;
      frame_r <= cif.frame_tick; // RULE17
      osc_en_r <= cif.osc_en; // RULE16 RULE18
      ext_r <= cif.ext_present;
    end
  end

  assign sck_out = sck_gen_r;
  assign sck_oe_n_out = sck_oe_n_r;
  assign serial_data_out = sdo_r;
  assign serial_data_oe_n_out = sdo_oe_n_r;
  assign conv_start_out = conv_start_r;
  assign conv_busy_out = conv_busy_r;
  assign conv_gain_out = conv_gain_r;
  assign conv_speed_2x_out = conv_speed_r;
  assign conv_temp_out = conv_temp_r;
  assign rejection_mode_out = rej_r;
  assign conv_clk_tick_out = tick_r;
  assign filter_frame_tick_out = frame_r;
  assign int_osc_en_out = osc_en_r;
  assign ext_clk_present_out = ext_r;

  AST_DESELECT_HIZ: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE11
    (cs_n_in && state_r != arsp_pkg::ARSP_ST_SHIFT) |=> (serial_data_oe_n_out && $stable(bit_cnt_r)))
    else $error("output driven or clock counted while deselected");

  AST_BUSY_FLAG: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE4
    (state_r == arsp_pkg::ARSP_ST_CONV) |=> serial_data_out)
    else $error("done flag low during conversion");

  AST_DONE_FLAG: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE12
    (state_r == arsp_pkg::ARSP_ST_CONV && conv_done_in && !cs_n_in) |=> ##1 !serial_data_out)
    else $error("done flag did not fall at completion");

  AST_ABORT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE3
    (state_r == arsp_pkg::ARSP_ST_SHIFT && cs_n_in) |=>
      (conv_start_out && state_r == arsp_pkg::ARSP_ST_CONV && bit_cnt_r == 5'h00))
    else $error("early deselect did not restart conversion");

  AST_LAST_FALL: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE14
    (state_r == arsp_pkg::ARSP_ST_SHIFT && sck_fall && bit_cnt_r == `ARSP_LAST_FALL && !cs_n_in) |=>
      (state_r == arsp_pkg::ARSP_ST_CONV && conv_start_out) ##1 serial_data_out)
    else $error("24th falling edge did not show the next done flag");

  AST_EXTRA_CLOCKS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE2
    (state_r == arsp_pkg::ARSP_ST_CONV && !conv_done_in && sck_fall) |=>
      (bit_cnt_r == 5'h00 && state_r == arsp_pkg::ARSP_ST_CONV) ##1 serial_data_out)
    else $error("extra clock during conversion was not ignored");

  AST_WORD_FORMAT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE1
    (state_r == arsp_pkg::ARSP_ST_CONV && conv_done_in) |=>
      (word_r[`ARSP_BIT_EOC] == 1'b0 && word_r[`ARSP_BIT_FILL] == 1'b0 &&
       word_r[3:0] == $past({conv_gain_r, conv_temp_r})))
    else $error("captured word has wrong status or echo");

  AST_FILLER: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE5
    (state_r == arsp_pkg::ARSP_ST_SHIFT && bit_cnt_r == 5'h01) |=> !serial_data_out)
    else $error("filler bit not low");

  AST_OVERRANGE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE7
    (state_r == arsp_pkg::ARSP_ST_CONV && conv_done_in && conv_value_in > `ARSP_POS_CLAMP) |=>
      (word_r[`ARSP_BIT_SIGN:`ARSP_BIT_MSB] == 2'b11 && word_r[19:4] == 16'h0000))
    else $error("overrange code wrong");

  AST_UNDERRANGE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE10
    (state_r == arsp_pkg::ARSP_ST_CONV && conv_done_in && conv_value_in < `ARSP_NEG_CLAMP) |=>
      (word_r[`ARSP_BIT_SIGN:`ARSP_BIT_MSB] == 2'b00 && word_r[19:4] == 16'hFFFF))
    else $error("underrange code wrong");

  AST_ZERO_CODE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE9
    (state_r == arsp_pkg::ARSP_ST_CONV && conv_done_in && conv_value_in == 20'sh0_0000) |=>
      (word_r[21:4] == 18'h2_0000))
    else $error("zero input code wrong");

  AST_HOLD: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE22
    (state_r != arsp_pkg::ARSP_ST_CONV) |=> $stable(word_r))
    else $error("result word changed before shift out");

  AST_TEMP_GAIN: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE21
    (start_nxt && temp_input_select_in) |=> (conv_gain_out == 3'h0 && !conv_speed_2x_out && conv_temp_out))
    else $error("temperature input did not force gain and speed");

  AST_REJ_DEFAULT: assert property (@(posedge ref_clk_in) // RULE15
    $rose(rst_n_in) |-> (rejection_mode_out == `ARSP_REJ_DEFAULT))
    else $error("rejection mode not at default after reset");

  AST_OUT_LIMIT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE20
    (state_r == arsp_pkg::ARSP_ST_SHIFT && sck_internal_in && !cs_n_in && out_tmr_r == OUT_MAX_L) |=>
      (state_r == arsp_pkg::ARSP_ST_CONV))
    else $error("internal clock output phase overran its limit");

endmodule : arsp_result_port
